// ==== shared/exec_pkg.sv ====
// Shared constants and types for the instruction execute subset
package exec_pkg;

  // ==========================================================
  // Operation codes presented by decode
  typedef enum logic [2:0] {
    OP_NONE     = 3'b000,
    OP_ADD_MEM  = 3'b001,
    OP_AND_WMEM = 3'b010,
    OP_AND_IMM  = 3'b011,
    OP_AND_MEM  = 3'b100,
    OP_CALL     = 3'b101,
    OP_ZERO_MEM = 3'b110
  } op_e;

  // ==========================================================
  // Sequencer states
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_WAIT  = 3'b001,
    ST_EXEC  = 3'b010,
    ST_CALL2 = 3'b011
  } state_e;

  // ==========================================================
  // Reset values and fixed figures
  // All ones: the AND paths only clear bits, so a zero start would leave nothing to test
  localparam logic [7:0] WREG_RST     = 8'hFF;
  localparam logic       FLAG_RST     = 1'b0;
  localparam logic [7:0] ZERO_BYTE    = 8'h00;
  localparam int         PC_INCREMENT = 1;
  localparam int         HALF_BIT     = 4;

endpackage

// ==== hw/byte_adder.sv ====
// Eight-bit adder with carry, half-carry and overflow outputs
`timescale 1ns/1ps
`default_nettype none

module byte_adder #(
  parameter int W = 8
) (
  input  wire logic [W-1:0] i_a,
  input  wire logic [W-1:0] i_b,
  output logic      [W-1:0] o_sum,
  output logic              o_carry,
  output logic              o_half_carry,
  output logic              o_overflow
);

  logic [W:0]               full;
  logic [exec_pkg::HALF_BIT:0] low;

  // ==========================================================
  // Arithmetic
  assign full  = {1'b0, i_a} + {1'b0, i_b};
  assign low   = {1'b0, i_a[exec_pkg::HALF_BIT-1:0]} + {1'b0, i_b[exec_pkg::HALF_BIT-1:0]};
  assign o_sum = full[W-1:0];
  assign o_carry      = full[W];                                  // RULE_08
  assign o_half_carry = low[exec_pkg::HALF_BIT];                  // RULE_08
  // Signed overflow: like-signed operands giving an opposite-signed result
  assign o_overflow   = (i_a[W-1] == i_b[W-1]) && (full[W-1] != i_a[W-1]); // RULE_08

endmodule

`default_nettype wire

// ==== hw/exec_unit.sv ====
// Execute stage for add, AND, call and clear-byte instructions
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// RULE_01: Add-to-memory sums working register and byte, writes byte, updates four flags.
// RULE_02: AND-memory puts working register AND byte into working register; zero flag only.
// RULE_03: AND-immediate puts working register AND immediate into working register; zero flag only.
// RULE_04: AND-into-memory writes byte AND working register back to that byte.
// RULE_05: Call pushes program counter plus one, then loads target; flags untouched.
// RULE_06: Call takes two instruction cycles.
// RULE_07: Clear-byte writes 00H to the byte; flags untouched.
// RULE_08: Zero on zero result, carry from bit 7, half-carry bit 3, signed overflow.
module exec_unit #(
  parameter int DATA_W = 8,
  parameter int ADDR_W = 8,
  parameter int PC_W   = 11
) (
  input  wire logic               i_clk,
  input  wire logic               i_srst,
  // Decoded instruction
  input  wire logic               i_valid,
  input  wire exec_pkg::op_e      i_op,
  input  wire logic [ADDR_W-1:0]  i_mem_addr,
  input  wire logic [DATA_W-1:0]  i_imm,
  input  wire logic [PC_W-1:0]    i_target,
  input  wire logic [PC_W-1:0]    i_pc,
  output logic                    o_ready,
  // Data memory
  output logic                    o_mem_rd,
  output logic                    o_mem_wr,
  output logic      [ADDR_W-1:0]  o_mem_addr,
  output logic      [DATA_W-1:0]  o_mem_wdata,
  input  wire logic [DATA_W-1:0]  i_mem_rdata,
  // Stack and program counter
  output logic                    o_push,
  output logic      [PC_W-1:0]    o_push_data,
  output logic                    o_pc_load,
  output logic      [PC_W-1:0]    o_pc_value,
  // Architectural state
  output logic      [DATA_W-1:0]  o_working_register,
  output logic                    o_zero_flag,
  output logic                    o_carry_flag,
  output logic                    o_half_carry_flag,
  output logic                    o_overflow_flag
);

  // ==========================================================
  // State
  exec_pkg::state_e   state_q;
  exec_pkg::op_e      op_q;
  logic               ready_q;
  logic               mem_rd_q;
  logic               mem_wr_q;
  logic [ADDR_W-1:0]  mem_addr_q;
  logic [DATA_W-1:0]  mem_wdata_q;
  logic               push_q;
  logic [PC_W-1:0]    push_data_q;
  logic               pc_load_q;
  logic [PC_W-1:0]    pc_value_q;
  logic [PC_W-1:0]    target_q;
  logic [DATA_W-1:0]  wreg_q;
  logic               zero_q;
  logic               carry_q;
  logic               half_q;
  logic               ovf_q;

  logic               take;
  logic [DATA_W-1:0]  sum;
  logic               sum_c;
  logic               sum_h;
  logic               sum_v;
  logic [DATA_W-1:0]  and_mem;
  logic [DATA_W-1:0]  and_imm;

  assign take    = i_valid && ready_q && (state_q == exec_pkg::ST_IDLE);
  assign and_mem = wreg_q & i_mem_rdata;
  assign and_imm = wreg_q & i_imm;

  byte_adder #(
    .W (DATA_W)
  ) u_adder (
    .i_a          (wreg_q),
    .i_b          (i_mem_rdata),
    .o_sum        (sum),
    .o_carry      (sum_c),
    .o_half_carry (sum_h),
    .o_overflow   (sum_v)
  );

  // ==========================================================
  // Sequencer
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      state_q <= exec_pkg::ST_IDLE;
      op_q    <= exec_pkg::OP_NONE;
      ready_q <= 1'b1;
    end else begin
      case (state_q)
        exec_pkg::ST_IDLE: begin
          if (take) begin
            op_q <= i_op;
            case (i_op)
              exec_pkg::OP_ADD_MEM, exec_pkg::OP_AND_WMEM, exec_pkg::OP_AND_MEM: begin
                state_q <= exec_pkg::ST_WAIT;
                ready_q <= 1'b0;
              end
              exec_pkg::OP_CALL: begin
                // Second cycle loads the target
                state_q <= exec_pkg::ST_CALL2;        // RULE_06
                ready_q <= 1'b0;
              end
              default: begin
                state_q <= exec_pkg::ST_IDLE;
              end
            endcase
          end
        end
        exec_pkg::ST_WAIT: begin
          // Memory answers one cycle after the read strobe
          state_q <= exec_pkg::ST_EXEC;
        end
        exec_pkg::ST_EXEC, exec_pkg::ST_CALL2: begin
          state_q <= exec_pkg::ST_IDLE;
          ready_q <= 1'b1;
        end
        default: begin
          state_q <= exec_pkg::ST_IDLE;
          ready_q <= 1'b1;
        end
      endcase
    end
  end

  // ==========================================================
  // Data memory port
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      mem_rd_q    <= 1'b0;
      mem_wr_q    <= 1'b0;
      mem_addr_q  <= '0;
      mem_wdata_q <= exec_pkg::ZERO_BYTE;
    end else begin
      mem_rd_q <= 1'b0;
      mem_wr_q <= 1'b0;
      if (take) begin
        mem_addr_q <= i_mem_addr;
        if (i_op == exec_pkg::OP_ADD_MEM || i_op == exec_pkg::OP_AND_WMEM ||
            i_op == exec_pkg::OP_AND_MEM) begin
          mem_rd_q <= 1'b1;
        end
        if (i_op == exec_pkg::OP_ZERO_MEM) begin
          mem_wr_q    <= 1'b1;
          mem_wdata_q <= exec_pkg::ZERO_BYTE;           // RULE_07
        end
      end else if (state_q == exec_pkg::ST_EXEC) begin
        if (op_q == exec_pkg::OP_ADD_MEM) begin
          mem_wr_q    <= 1'b1;
          mem_wdata_q <= sum;                           // RULE_01
        end else if (op_q == exec_pkg::OP_AND_MEM) begin
          mem_wr_q    <= 1'b1;
          mem_wdata_q <= and_mem;                       // RULE_04
        end
      end
    end
  end

  // ==========================================================
  // Stack push and program counter load
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      push_q      <= 1'b0;
      push_data_q <= '0;
      pc_load_q   <= 1'b0;
      pc_value_q  <= '0;
      target_q    <= '0;
    end else begin
      push_q    <= 1'b0;
      pc_load_q <= 1'b0;
      if (take && i_op == exec_pkg::OP_CALL) begin
        // Return address is the instruction after the call
        push_q      <= 1'b1;
        push_data_q <= i_pc + PC_W'(exec_pkg::PC_INCREMENT); // RULE_05
        target_q    <= i_target;
      end
      if (state_q == exec_pkg::ST_CALL2) begin
        pc_load_q  <= 1'b1;                             // RULE_05
        pc_value_q <= target_q;
      end
    end
  end

  // ==========================================================
  // Working register
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      wreg_q <= exec_pkg::WREG_RST;
    end else if (take && i_op == exec_pkg::OP_AND_IMM) begin
      wreg_q <= and_imm;                                // RULE_03
    end else if (state_q == exec_pkg::ST_EXEC && op_q == exec_pkg::OP_AND_WMEM) begin
      wreg_q <= and_mem;                                // RULE_02
    end
  end

  // ==========================================================
  // Flags; call and clear-byte never reach here, so flags hold
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      zero_q  <= exec_pkg::FLAG_RST;
      carry_q <= exec_pkg::FLAG_RST;
      half_q  <= exec_pkg::FLAG_RST;
      ovf_q   <= exec_pkg::FLAG_RST;
    end else if (take && i_op == exec_pkg::OP_AND_IMM) begin
      zero_q <= (and_imm == '0);                        // RULE_03
    end else if (state_q == exec_pkg::ST_EXEC) begin
      case (op_q)
        exec_pkg::OP_ADD_MEM: begin
          zero_q  <= (sum == '0);                       // RULE_01
          carry_q <= sum_c;                             // RULE_08
          half_q  <= sum_h;
          ovf_q   <= sum_v;
        end
        exec_pkg::OP_AND_WMEM, exec_pkg::OP_AND_MEM: begin
          zero_q <= (and_mem == '0);                    // RULE_02
        end
        default: begin
          zero_q <= zero_q;
        end
      endcase
    end
  end

  // ==========================================================
  // Outputs
  assign o_ready            = ready_q;
  assign o_mem_rd           = mem_rd_q;
  assign o_mem_wr           = mem_wr_q;
  assign o_mem_addr         = mem_addr_q;
  assign o_mem_wdata        = mem_wdata_q;
  assign o_push             = push_q;
  assign o_push_data        = push_data_q;
  assign o_pc_load          = pc_load_q;
  assign o_pc_value         = pc_value_q;
  assign o_working_register = wreg_q;
  assign o_zero_flag        = zero_q;
  assign o_carry_flag       = carry_q;
  assign o_half_carry_flag  = half_q;
  assign o_overflow_flag    = ovf_q;

endmodule

`default_nettype wire

// ==== test/exec_unit_chk.sv ====
// Port-level assertions for the execute stage
`timescale 1ns/1ps
`default_nettype none
module exec_unit_chk (
  input wire logic           i_clk,
  input wire logic           i_srst,
  input wire logic           i_valid,
  input wire exec_pkg::op_e  i_op,
  input wire logic [7:0]     i_imm,
  input wire logic [10:0]    i_target,
  input wire logic [10:0]    i_pc,
  input wire logic [7:0]     i_mem_rdata,
  input wire logic           o_ready,
  input wire logic           o_mem_rd,
  input wire logic           o_mem_wr,
  input wire logic [7:0]     o_mem_wdata,
  input wire logic           o_push,
  input wire logic [10:0]    o_push_data,
  input wire logic           o_pc_load,
  input wire logic [10:0]    o_pc_value,
  input wire logic [7:0]     o_working_register,
  input wire logic           o_zero_flag,
  input wire logic           o_carry_flag,
  input wire logic           o_half_carry_flag,
  input wire logic           o_overflow_flag
);
  logic       tk;
  logic [3:0] fl;
  assign tk = i_valid && o_ready;
  assign fl = {o_zero_flag, o_carry_flag, o_half_carry_flag, o_overflow_flag};
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_srst);
  // ==========================================================
  // Results and timing
  a_add_result: assert property (
    tk && i_op == exec_pkg::OP_ADD_MEM |=> o_mem_rd ##2 o_mem_wr
    && o_mem_wdata == o_working_register + $past(i_mem_rdata)
    && o_zero_flag == (o_mem_wdata == 8'h00)
    && o_carry_flag == (({1'b0, o_working_register} + {1'b0, $past(i_mem_rdata)}) > 9'h0FF)
    && o_half_carry_flag == ((o_working_register[3:0] + $past(i_mem_rdata[3:0])) > 5'h0F)
    && o_overflow_flag == ((o_working_register[7] == $past(i_mem_rdata[7]))
    && (o_mem_wdata[7] != o_working_register[7])))
    else $error("add result wrong");
  a_and_wreg: assert property (
    tk && i_op == exec_pkg::OP_AND_WMEM |=> o_mem_rd ##2 !o_mem_wr
    && o_working_register == ($past(o_working_register) & $past(i_mem_rdata)))
    else $error("and into working register wrong");
  a_and_imm: assert property (
    tk && i_op == exec_pkg::OP_AND_IMM |=> o_working_register == $past(o_working_register & i_imm)
    && o_zero_flag == (o_working_register == 8'h00)) else $error("and immediate wrong");
  a_and_mem: assert property (
    tk && i_op == exec_pkg::OP_AND_MEM |=> ##2 o_mem_wr
    && o_mem_wdata == (o_working_register & $past(i_mem_rdata))) else $error("and into byte wrong");
  a_call_push: assert property (
    tk && i_op == exec_pkg::OP_CALL |=> o_push && o_push_data == $past(i_pc) + 11'h001)
    else $error("call push wrong");
  a_call_two_cycles: assert property (
    tk && i_op == exec_pkg::OP_CALL |=> !o_ready && !o_pc_load ##1 o_ready && o_pc_load
    && o_pc_value == $past(i_target, 2)) else $error("call timing or target wrong");
  a_zero_byte: assert property (
    tk && i_op == exec_pkg::OP_ZERO_MEM |=> o_mem_wr && o_mem_wdata == 8'h00)
    else $error("clear byte wrong");
  a_flags_kept: assert property (
    tk && (i_op == exec_pkg::OP_CALL || i_op == exec_pkg::OP_ZERO_MEM) |=> $stable(fl))
    else $error("flags changed");
  c_call: cover property (tk && i_op == exec_pkg::OP_CALL);
  c_add: cover property (tk && i_op == exec_pkg::OP_ADD_MEM);
  c_zero: cover property (tk && i_op == exec_pkg::OP_ZERO_MEM);
endmodule
bind exec_unit exec_unit_chk i_chk (.i_clk(i_clk), .i_srst(i_srst), .i_valid(i_valid),
  .i_op(i_op), .i_imm(i_imm), .i_target(i_target), .i_pc(i_pc), .i_mem_rdata(i_mem_rdata),
  .o_ready(o_ready), .o_mem_rd(o_mem_rd), .o_mem_wr(o_mem_wr), .o_mem_wdata(o_mem_wdata),
  .o_push(o_push), .o_push_data(o_push_data), .o_pc_load(o_pc_load), .o_pc_value(o_pc_value),
  .o_working_register(o_working_register), .o_zero_flag(o_zero_flag),
  .o_carry_flag(o_carry_flag), .o_half_carry_flag(o_half_carry_flag),
  .o_overflow_flag(o_overflow_flag));
`default_nettype wire

// ==== test/exec_unit_tb.sv ====
// Self-checking bench for the execute stage
`timescale 1ns/1ps
`default_nettype none
module exec_unit_tb;
  logic i_clk, i_srst, i_valid, o_ready, o_mem_rd, o_mem_wr, o_push, o_pc_load;
  logic zf, cf, hf, vf;
  exec_pkg::op_e i_op;
  logic [7:0]  i_mem_addr, i_imm, i_mem_rdata, o_mem_addr, o_mem_wdata, o_working_register;
  logic [10:0] i_target, i_pc, o_push_data, o_pc_value, got_push, got_pc;
  logic [7:0]  mem [256];
  int          num_errors, n_tests, cycles;
  exec_unit i_dut (.i_clk(i_clk), .i_srst(i_srst), .i_valid(i_valid), .i_op(i_op),
    .i_mem_addr(i_mem_addr), .i_imm(i_imm), .i_target(i_target), .i_pc(i_pc), .o_ready(o_ready),
    .o_mem_rd(o_mem_rd), .o_mem_wr(o_mem_wr), .o_mem_addr(o_mem_addr), .o_mem_wdata(o_mem_wdata),
    .i_mem_rdata(i_mem_rdata), .o_push(o_push), .o_push_data(o_push_data),
    .o_pc_load(o_pc_load), .o_pc_value(o_pc_value), .o_working_register(o_working_register),
    .o_zero_flag(zf), .o_carry_flag(cf), .o_half_carry_flag(hf), .o_overflow_flag(vf));
  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end
  // ==========================================================
  // Data memory: one-cycle read; outside the read slot the data line toggles
  always @(posedge i_clk) begin
    if (o_mem_wr) mem[o_mem_addr] <= o_mem_wdata;
    i_mem_rdata <= o_mem_rd ? mem[o_mem_addr] : ~i_mem_rdata;
    if (o_push) got_push <= o_push_data;
    if (o_pc_load) got_pc <= o_pc_value;
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      num_errors++;
      conclude();
    end
  end
  task automatic conclude();
    if (num_errors == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // ==========================================================
  // One instruction, with its expected effect worked out here
  logic [7:0] w;
  logic       z, c, ac, ov;
  task automatic run(input exec_pkg::op_e op, input logic [7:0] a, input logic [7:0] x,
                     input logic [10:0] pc, input logic [10:0] tg, input int cyc);
    int         n;
    logic [7:0] m, me;
    logic [8:0] s;
    n = 1;
    m = mem[a];
    me = m;
    s = {1'b0, w} + {1'b0, m};
    case (op)
      exec_pkg::OP_ADD_MEM: begin
        me = s[7:0];
        c = s[8];
        ac = (w[3:0] + m[3:0]) > 15;
        ov = (w[7] == m[7]) && (s[7] != w[7]);
        z = (me == 8'h00);
      end
      exec_pkg::OP_AND_WMEM: w = w & m;
      exec_pkg::OP_AND_IMM: w = w & x;
      exec_pkg::OP_AND_MEM: me = w & m;
      exec_pkg::OP_ZERO_MEM: me = 8'h00;
      default: ;
    endcase
    if (op inside {exec_pkg::OP_AND_WMEM, exec_pkg::OP_AND_IMM}) z = (w == 8'h00);
    if (op == exec_pkg::OP_AND_MEM) z = (me == 8'h00);
    @(posedge i_clk);
    i_valid <= 1'b1;
    i_op <= op;
    i_mem_addr <= a;
    i_imm <= x;
    i_pc <= pc;
    i_target <= tg;
    @(posedge i_clk);
    i_valid <= 1'b0;
    #1;
    while (o_ready !== 1'b1 && n < 8) begin
      @(posedge i_clk);
      #1;
      n++;
    end
    @(posedge i_clk);
    #1;
    chk(16'(n), 16'(cyc));
    chk({8'h00, mem[a]}, {8'h00, me});
    chk({8'h00, o_working_register}, {8'h00, w});
    chk({12'h000, zf, cf, hf, vf}, {12'h000, z, c, ac, ov});
    if (op == exec_pkg::OP_CALL) begin
      chk({5'h00, got_push}, {5'h00, 11'(pc + 11'h001)});
      chk({5'h00, got_pc}, {5'h00, tg});
    end
  endtask
  initial begin
    {i_srst, i_valid, i_mem_addr, i_imm, i_target, i_pc, i_mem_rdata} = '0;
    i_srst = 1'b1;
    i_op = exec_pkg::OP_NONE;
    {num_errors, n_tests, cycles, got_push, got_pc} = '0;
    w = exec_pkg::WREG_RST;
    {z, c, ac, ov} = {4{exec_pkg::FLAG_RST}};
    foreach (mem[k]) mem[k] = 8'(k * 37);
    mem[8'h10] = 8'h80;
    mem[8'h11] = 8'h00;
    mem[8'h12] = 8'h5A;
    repeat (12) @(posedge i_clk);
    i_srst <= 1'b0;
    run(exec_pkg::OP_ADD_MEM, 8'h11, 8'h00, 11'h000, 11'h000, 3);
    run(exec_pkg::OP_ADD_MEM, 8'h10, 8'h00, 11'h000, 11'h000, 3);
    run(exec_pkg::OP_ZERO_MEM, 8'h10, 8'h00, 11'h000, 11'h000, 1);
    run(exec_pkg::OP_CALL, 8'h00, 8'h00, 11'h7FF, 11'h123, 2);
    run(exec_pkg::OP_CALL, 8'h00, 8'h00, 11'h2A5, 11'h5DA, 2);
    run(exec_pkg::OP_NONE, 8'h12, 8'h00, 11'h000, 11'h000, 1);
    run(exec_pkg::OP_AND_IMM, 8'h00, 8'h3C, 11'h000, 11'h000, 1);
    run(exec_pkg::OP_AND_WMEM, 8'h12, 8'h00, 11'h000, 11'h000, 3);
    run(exec_pkg::OP_ADD_MEM, 8'h13, 8'h00, 11'h000, 11'h000, 3);
    run(exec_pkg::OP_AND_MEM, 8'h12, 8'h00, 11'h000, 11'h000, 3);
    run(exec_pkg::OP_AND_IMM, 8'h00, 8'h00, 11'h000, 11'h000, 1);
    // ==========================================================
    // Reset in mid-run brings the working register back for the next AND
    @(posedge i_clk);
    i_srst <= 1'b1;
    repeat (2) @(posedge i_clk);
    i_srst <= 1'b0;
    w = exec_pkg::WREG_RST;
    {z, c, ac, ov} = {4{exec_pkg::FLAG_RST}};
    run(exec_pkg::OP_AND_IMM, 8'h00, 8'h81, 11'h000, 11'h000, 1);
    conclude();
  end
endmodule
`default_nettype wire
